/* File: smbus_host_model.sv */
// Purpose: Bus host driving SCL and SDA for the slave port
// Assumes: 160 ns SCL period, SDA pulled up on the board
// Notes:   Calls start at a clock edge plus 1 ns
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  // Bus pins
  input  wire logic i_sda,
  output var logic  o_scl,
  output var logic  o_sda_oe
);
  // SCL idles high outside frames
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // Start or repeated start, leaves SCL low
  task automatic start();
    if (!o_scl) begin
      #40 o_sda_oe = 1'b0;
      #40 o_scl = 1'b1;
    end
    #40 o_sda_oe = 1'b1;
    #40 o_scl = 1'b0;
  endtask
  // Eight data bits then the acknowledge slot, MSB first
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #40 o_sda_oe = ~tx[i];
      #40 o_scl = 1'b1;
      #40 rx[i] = i_sda;
      #40 o_scl = 1'b0;
    end
  endtask
  // Pull low in SCL low, then release while SCL is high
  task automatic stop();
    #40 o_sda_oe = 1'b1;
    #40 o_scl = 1'b1;
    #40 o_sda_oe = 1'b0;
    #40;
  endtask
endmodule // smbus_host_model
`default_nettype wire

/* File: smbus_port_defines.vh */
// Purpose: Constants for the two-wire slave register port
// Assumes: 200 MHz system clock, 8-bit registers
// Notes:   Register file is a small internal array indexed by the pointer
`ifndef SMBUS_PORT_DEFINES_VH
`define SMBUS_PORT_DEFINES_VH

// Register map
`define REG_BLOCK_READ_LENGTH  7'h00
`define BLOCK_LEN_RESET        8'h01
`define NUM_REGS               128
`define BLOCK_MAX              8'h20

// Field positions
`define ADDR_MSB_BIT           7

// Fixed slave addresses chosen by strap level
`define SLAVE_ADDR_BASE        7'h50

// Clocks after reset release before the synchronised strap is captured
`define STRAP_SETTLE           2'h2

// Byte phase counts
`define BIT_LAST               4'h7
`define BIT_ACK                4'h8

`endif

/* File: smbus_port_monitor.sv */
// Purpose: Port checker for the two-wire slave register port
// Assumes: Pins sampled by the 200 MHz system clock
// Notes:   Bound to every instance of the port
`timescale 1ns/1ps
`default_nettype none
module smbus_port_monitor (
  // System
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  // Bus pins
  input wire logic [1:0] i_strap_select_pin,
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       o_sda_out,
  input wire logic       o_sda_oe,
  // Status
  input wire logic [7:0] o_register_pointer,
  input wire logic       o_busy
);
  // One clock domain, so one clocking and one reset for all checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("sda drive moved while scl high");
  a_oe_holds_high: assert property ($rose(i_scl) |-> ##1 $stable(o_sda_oe)[*8])
    else $error("sda drive not steady in scl high");
  a_busy_on_start: assert property (($fell(i_sda) && i_scl) |-> ##[1:8] o_busy)
    else $error("start not taken");
  a_busy_off_stop: assert property (($rose(i_sda) && i_scl) |-> ##[1:8] !o_busy)
    else $error("stop not taken");
  a_idle_no_drive: assert property ((!o_busy && !$past(o_busy)) |-> !o_sda_oe)
    else $error("sda driven while idle");
  a_ptr_only_busy: assert property ($changed(o_register_pointer) |-> o_busy)
    else $error("pointer moved outside a transfer");
  a_sda_out_low: assert property (o_sda_out == 1'b0)
    else $error("open drain output not low");
  a_reset_values: assert property ($rose(i_rst_n) |-> (o_register_pointer == 8'h00
    && !o_busy && !o_sda_oe))
    else $error("bad values after reset");
endmodule // smbus_port_monitor
bind smbus_slave_register_port smbus_port_monitor u_monitor (.i_sys_clk, .i_rst_n,
  .i_strap_select_pin, .i_scl, .i_sda, .o_sda_out, .o_sda_oe, .o_register_pointer, .o_busy);
`default_nettype wire

/* File: smbus_slave_register_port.v */
// Purpose: Two-wire slave port giving a host access to internal registers
// Assumes: SCL/SDA sampled by the 200 MHz clock; bus clock far slower
// Notes:   Open-drain SDA as three signals; SCL is input only
// How it works
// - Slave address latched from strap after reset
// - Start is SDA fall with SCL high
// - Matching address acked before ninth pulse
// - Direction bit 0 writes, 1 reads
// - Nine pulses per byte, SDA steady while SCL high
// - SDA rise with SCL high is stop
// - Direction fixed until a new start
// - First write byte loads pointer, then data
// - Reads return pointer-selected register
// - Address MSB chooses single or block access
// - Block read length from register zero
// - Block write count supplied by host
// - Send byte, write byte, block write supported
// - Send byte only updates the pointer
// - Repeated start after send byte allowed
// - Write byte MSB one means block write
// - Block write count then data, max 32
// - Block read sends count before data
// - Receive byte reads previously set register
`timescale 1ns/1ps
`default_nettype none
`include "smbus_port_defines.vh"

module smbus_slave_register_port (
  // System
  input  wire       i_sys_clk,
  input  wire       i_rst_n,
  // Strap select pin levels, static after power-up
  input  wire [1:0] i_strap_select_pin,
  // Bus pins
  input  wire       i_scl,
  input  wire       i_sda,
  output wire       o_sda_out,
  output wire       o_sda_oe,
  // Status
  output reg  [7:0] o_register_pointer,
  output reg        o_busy
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_WRITE = 3'h2;
  localparam ST_READ  = 3'h3;
  localparam ST_SKIP  = 3'h4;

  localparam PH_PTR   = 2'h0;
  localparam PH_COUNT = 2'h1;
  localparam PH_DATA  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers: pins pass two flip-flops before any logic reads them
  wire       scl_s;
  wire       sda_s;
  wire [1:0] strap_s;
  reg        scl_d_reg;
  reg        sda_d_reg;
  reg        rise_seen_reg;

  // Bus pins idle high; the strap has no idle level, so low is used
  pin_sync #(
    .WIDTH     (1),
    .IDLE_HIGH (1'b1)
  ) u_scl_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_pin     (i_scl),
    .o_level   (scl_s)
  );

  pin_sync #(
    .WIDTH     (1),
    .IDLE_HIGH (1'b1)
  ) u_sda_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_pin     (i_sda),
    .o_level   (sda_s)
  );

  pin_sync #(
    .WIDTH     (2),
    .IDLE_HIGH (1'b0)
  ) u_strap_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_pin     (i_strap_select_pin),
    .o_level   (strap_s)
  );

  // Delayed copies for edge detection, reset to the idle level
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  wire scl_rise  = scl_s & ~scl_d_reg;
  // Only a fall after a rise in this frame ends a bit; the fall that
  // closes a start condition would otherwise count as the first bit
  wire scl_fall  = ~scl_s & scl_d_reg & rise_seen_reg;
  // Data changes only while SCL is low, so these edges are unambiguous
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // Cleared by each start, set by the first SCL rise after it
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rise_seen_reg <= 1'b0;
    end else if (start_det) begin
      rise_seen_reg <= 1'b0;
    end else if (scl_rise) begin
      rise_seen_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture: waits until the synchronised level has settled
  reg       strap_done_reg;
  reg [1:0] strap_wait_reg;
  reg [6:0] slave_addr_reg;

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_done_reg <= 1'b0;
      strap_wait_reg <= 2'h0;
      slave_addr_reg <= `SLAVE_ADDR_BASE;
    end else if (!strap_done_reg) begin
      if (strap_wait_reg == `STRAP_SETTLE) begin
        strap_done_reg <= 1'b1;
        // Fixed until the next reset; no assign-address path exists
        slave_addr_reg <= `SLAVE_ADDR_BASE | {5'h00, strap_s};
      end else begin
        strap_wait_reg <= strap_wait_reg + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  reg [7:0] regs [0:`NUM_REGS-1];
  wire [6:0] ptr_idx = o_register_pointer[6:0];
  wire [7:0] block_len = regs[`REG_BLOCK_READ_LENGTH];

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine
  reg [2:0] state_reg;
  reg [3:0] bit_reg;
  reg [7:0] shift_reg;
  reg       sda_low_reg;
  reg [1:0] phase_reg;
  reg [7:0] count_reg;
  reg       rd_first_reg;
  reg       host_nack_reg;
  reg       wr_en_reg;
  reg [6:0] wr_idx_reg;
  reg [7:0] wr_data_reg;

  wire [7:0] rx_byte   = {shift_reg[6:0], sda_s};
  wire       block_sel = o_register_pointer[`ADDR_MSB_BIT];
  // Block reads begin with the length byte, then registers in order
  wire [7:0] rd_value  = (block_sel && rd_first_reg) ? block_len : regs[ptr_idx];

  assign o_sda_out = 1'b0;
  assign o_sda_oe  = sda_low_reg;

  // Register write port, one write per received data byte, none for block bytes past the count
  always @(posedge i_sys_clk) begin
    if (wr_en_reg) begin
      regs[wr_idx_reg] <= wr_data_reg;
    end
  end

  // Bus state machine; SDA drive is set and released on SCL falling edges, and also released at start or stop
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg          <= ST_IDLE;
      bit_reg            <= 4'h0;
      shift_reg          <= 8'h00;
      sda_low_reg        <= 1'b0;
      phase_reg          <= PH_PTR;
      count_reg          <= 8'h00;
      rd_first_reg       <= 1'b0;
      host_nack_reg      <= 1'b0;
      wr_en_reg          <= 1'b0;
      wr_idx_reg         <= 7'h00;
      wr_data_reg        <= 8'h00;
      o_register_pointer <= 8'h00;
      o_busy             <= 1'b0;
    end else begin
      wr_en_reg <= 1'b0;
      if (start_det) begin
        // Start or repeated start: new operation, new direction
        state_reg   <= ST_ADDR;
        bit_reg     <= 4'h0;
        sda_low_reg <= 1'b0;
        o_busy      <= 1'b1;
      end else if (stop_det) begin
        state_reg   <= ST_IDLE;
        sda_low_reg <= 1'b0;
        o_busy      <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE, ST_SKIP: begin
            sda_low_reg <= 1'b0;
          end
          ST_ADDR, ST_WRITE: begin
            if (scl_rise && bit_reg <= `BIT_LAST) begin
              shift_reg <= rx_byte;
            end
            if (scl_fall) begin
              if (bit_reg == `BIT_LAST) begin
                bit_reg <= `BIT_ACK;
                if (state_reg == ST_ADDR) begin
                  if (shift_reg[7:1] == slave_addr_reg) begin
                    sda_low_reg <= 1'b1;
                  end else begin
                    state_reg <= ST_SKIP;
                  end
                end else begin
                  sda_low_reg <= 1'b1;
                end
              end else if (bit_reg == `BIT_ACK) begin
                bit_reg     <= 4'h0;
                sda_low_reg <= 1'b0;
                if (state_reg == ST_ADDR) begin
                  if (shift_reg[0]) begin
                    // Read: drive first bit right after the address ack
                    state_reg     <= ST_READ;
                    rd_first_reg  <= 1'b1;
                    host_nack_reg <= 1'b0;
                    shift_reg     <= rd_value;
                    sda_low_reg   <= ~rd_value[7];
                  end else begin
                    state_reg <= ST_WRITE;
                    phase_reg <= PH_PTR;
                  end
                end else begin
                  case (phase_reg)
                    PH_PTR: begin
                      // Send byte ends here; repeated start may follow
                      o_register_pointer <= shift_reg;
                      phase_reg <= shift_reg[`ADDR_MSB_BIT] ? PH_COUNT : PH_DATA;
                    end
                    PH_COUNT: begin
                      count_reg <= (shift_reg > `BLOCK_MAX) ? `BLOCK_MAX : shift_reg;
                      phase_reg <= PH_DATA;
                    end
                    default: begin
                      // Data byte into the selected register
                      if (!block_sel || count_reg != 8'h00) begin
                        wr_en_reg   <= 1'b1;
                        wr_idx_reg  <= ptr_idx;
                        wr_data_reg <= shift_reg;
                      end
                      if (block_sel) begin
                        if (count_reg != 8'h00) begin
                          count_reg          <= count_reg - 8'h01;
                          o_register_pointer <= {1'b1, ptr_idx + 7'h01};
                        end
                      end
                    end
                  endcase
                end
              end else begin
                bit_reg <= bit_reg + 4'h1;
              end
            end
          end
          ST_READ: begin
            if (scl_rise && bit_reg == `BIT_ACK) begin
              host_nack_reg <= sda_s;
            end
            if (scl_fall) begin
              if (bit_reg == `BIT_LAST) begin
                bit_reg     <= `BIT_ACK;
                sda_low_reg <= 1'b0;
              end else if (bit_reg == `BIT_ACK) begin
                bit_reg <= 4'h0;
                if (host_nack_reg) begin
                  // Host is done; wait released for its stop
                  state_reg   <= ST_SKIP;
                  sda_low_reg <= 1'b0;
                end else begin
                  if (block_sel && !rd_first_reg) begin
                    // Block reads step through consecutive registers
                    o_register_pointer <= {1'b1, ptr_idx + 7'h01};
                    shift_reg   <= regs[ptr_idx + 7'h01];
                    sda_low_reg <= ~regs[ptr_idx + 7'h01][7];
                  end else begin
                    shift_reg   <= regs[ptr_idx];
                    sda_low_reg <= ~regs[ptr_idx][7];
                  end
                  rd_first_reg <= 1'b0;
                end
              end else begin
                bit_reg     <= bit_reg + 4'h1;
                shift_reg   <= {shift_reg[6:0], 1'b0};
                sda_low_reg <= ~shift_reg[6];
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // smbus_slave_register_port

////////////////////////////////////////////////////////////////////////////////
// Two flip-flop synchroniser for pins from outside the clock domain; the
// reset level matches the pin's idle level so no false edge follows reset
module pin_sync #(
  parameter       WIDTH     = 1,
  parameter [0:0] IDLE_HIGH = 1'b1
) (
  // Clock and reset
  input  wire             i_sys_clk,
  input  wire             i_rst_n,
  // Pin and its level in this clock domain
  input  wire [WIDTH-1:0] i_pin,
  output wire [WIDTH-1:0] o_level
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // Only the second stage leaves this module
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= {WIDTH{IDLE_HIGH}};
      sync_reg <= {WIDTH{IDLE_HIGH}};
    end else begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
    end
  end

  assign o_level = sync_reg;

endmodule // pin_sync
`default_nettype wire

/* File: test_smbus_slave_register_port.sv */
// Purpose: Self-checking bench for the slave register port
// Assumes: Strap at level 2, then level 1 after a second reset
// Notes:   Each scenario is a task that judges its own results
`timescale 1ns/1ps
`default_nettype none
`include "smbus_port_defines.vh"
module test_smbus_slave_register_port;
  localparam logic [6:0] own_addr = `SLAVE_ADDR_BASE | 7'h02;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] strap = 2'h2;
  wire        scl;
  wire        host_oe;
  wire        dut_out;
  wire        dut_oe;
  wire  [7:0] ptr;
  wire        busy;
  int         num_errors = 0;
  int         tests_run = 0;
  // Open-drain wire with pull-up
  wire sda = (dut_oe ? dut_out : 1'b1) & ~host_oe;
  always #2.5 clk = ~clk;
  smbus_slave_register_port u_dut (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_strap_select_pin(strap), .i_scl(scl), .i_sda(sda), .o_sda_out(dut_out),
    .o_sda_oe(dut_oe), .o_register_pointer(ptr), .o_busy(busy));
  smbus_host_model u_host (.i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));
  ////////////////////////////////////////
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Host sends a byte; bus must show it plus the expected ack level
  task automatic wr(input logic [7:0] b, input logic ack);
    logic [8:0] rx;
    u_host.xfer({b, 1'b1}, rx);
    chk(rx, {b, ack});
  endtask
  // Host reads a byte and answers ack or nack
  task automatic rd(input logic [7:0] b, input logic nack);
    logic [8:0] rx;
    u_host.xfer({8'hFF, nack}, rx);
    chk(rx, {b, nack});
  endtask
  ////////////////////////////////////////
  task automatic t_write_read();
    u_host.start();
    chk({8'h00, busy}, 9'h001);
    wr({own_addr, 1'b0}, 1'b0);
    wr(8'h05, 1'b0);
    wr(8'hA5, 1'b0);
    u_host.stop();
    chk({1'b0, ptr}, 9'h005);
    chk({8'h00, busy}, 9'h000);
    u_host.start();
    wr({own_addr, 1'b1}, 1'b0);
    rd(8'hA5, 1'b1);
    u_host.stop();
  endtask
  task automatic t_block();
    u_host.start();
    wr({own_addr, 1'b0}, 1'b0);
    wr(8'h00, 1'b0);
    wr(8'h03, 1'b0);
    u_host.stop();
    u_host.start();
    wr({own_addr, 1'b0}, 1'b0);
    wr(8'h90, 1'b0);
    // Pointer follows the SCL fall by the synchroniser delay
    #40 chk({1'b0, ptr}, 9'h090);
    wr(8'h02, 1'b0);
    wr(8'h11, 1'b0);
    wr(8'h22, 1'b0);
    u_host.stop();
    u_host.start();
    wr({own_addr, 1'b0}, 1'b0);
    wr(8'h90, 1'b0);
    u_host.start();
    wr({own_addr, 1'b1}, 1'b0);
    rd(8'h03, 1'b0);
    rd(8'h11, 1'b0);
    rd(8'h22, 1'b1);
    u_host.stop();
  endtask
  task automatic t_send_rep();
    u_host.start();
    wr({own_addr, 1'b0}, 1'b0);
    wr(8'h05, 1'b0);
    u_host.start();
    wr({own_addr, 1'b1}, 1'b0);
    rd(8'hA5, 1'b1);
    u_host.stop();
  endtask
  task automatic t_foreign();
    u_host.start();
    wr({own_addr ^ 7'h01, 1'b0}, 1'b1);
    wr(8'h07, 1'b1);
    u_host.stop();
    chk({1'b0, ptr}, 9'h005);
  endtask
  // Second reset with another strap level; only the new address answers
  task automatic t_strap();
    strap = 2'h1;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk({1'b0, ptr}, 9'h000);
    u_host.start();
    wr({`SLAVE_ADDR_BASE | 7'h01, 1'b0}, 1'b0);
    wr(8'h06, 1'b0);
    u_host.stop();
    chk({1'b0, ptr}, 9'h006);
    u_host.start();
    wr({own_addr, 1'b0}, 1'b1);
    u_host.stop();
  endtask
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Run takes about 43 us, so 200 us means a hang
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    t_write_read();
    t_block();
    t_send_rep();
    t_foreign();
    t_strap();
    print_verdict();
  end
endmodule // test_smbus_slave_register_port
`default_nettype wire
